// file: rtl/tric_pkg.sv
// tric_pkg: register map, field layout, reset values and enumerations
// for the two-rank input capture block.
// assumes a 32-bit apb slave with word-aligned registers.
package tric_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] TRIC_CTRL_OFF = 12'h000;
  localparam logic [11:0] TRIC_CMD_OFF = 12'h004;
  localparam logic [11:0] TRIC_STAT_OFF = 12'h008;
  localparam logic [11:0] TRIC_RANK1_OFF = 12'h00C;
  localparam logic [11:0] TRIC_RANK2_OFF = 12'h010;
  localparam logic [11:0] TRIC_READ_OFF = 12'h014;

  // ==========================================================================
  // control field positions
  localparam int TRIC_CTRL_POLICY_BIT = 0;
  localparam int TRIC_CTRL_WAIT_BIT = 1;
  localparam int TRIC_CTRL_S1SRC_LSB = 4;
  localparam int TRIC_CTRL_S2SRC_LSB = 8;
  localparam int TRIC_CMD_S1_BIT = 0;
  localparam int TRIC_CMD_S2_BIT = 1;

  localparam int TRIC_CHANNELS = 16;

  // trigger sources, 2 bits each
  localparam logic [1:0] TRIC_SRC_HOLD = 2'h0;
  localparam logic [1:0] TRIC_SRC_EXT = 2'h1;
  localparam logic [1:0] TRIC_SRC_READ = 2'h2;
  localparam logic [1:0] TRIC_SRC_SW = 2'h3;

  // reset values
  localparam logic TRIC_POLICY_RST = 1'b0;
  localparam logic TRIC_WAIT_RST = 1'b0;
  localparam logic [1:0] TRIC_S1SRC_RST = 2'h2;
  localparam logic [1:0] TRIC_S2SRC_RST = 2'h2;

  typedef enum logic {tric_every_trigger, tric_first_after_transfer} tric_policy_t;
  typedef enum logic {tric_immediate_read_mode, tric_new_data_wait_mode} tric_rmode_t;

  typedef struct packed {
    tric_policy_t capture_policy_select;
    tric_rmode_t read_wait_select;
    logic [1:0] stage_one_source_select;
    logic [1:0] stage_two_source_select;
  } tric_cfg_t;

  localparam tric_cfg_t TRIC_CFG_RST = '{
    capture_policy_select: tric_every_trigger,
    read_wait_select: tric_immediate_read_mode,
    stage_one_source_select: TRIC_S1SRC_RST,
    stage_two_source_select: TRIC_S2SRC_RST
  };

endpackage : tric_pkg

// file: rtl/tric_edge_sync.sv
// tric_edge_sync: three-flop synchroniser and falling-edge pulse maker
// for the external stage-one and stage-two trigger pins.
// assumes the pin is asynchronous to pclk and held low or high >= 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module tric_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic fall_pulse
);

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic level;

  // ==========================================================================
  // synchroniser; sync_a feeds only sync_b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // falling edge counts once second and third stages agree on the new low;
  // a glitch shorter than two cycles never makes them agree, so it is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      if (sync_b == sync_c) begin
        level <= sync_c;
      end
      fall_pulse <= level & ~sync_b & ~sync_c;
    end
  end

endmodule : tric_edge_sync
`default_nettype wire

// file: rtl/tric_capture.sv
// tric_capture: two-rank capture of sixteen input channels with capture
// policy, read-wait mode and selectable stage-one/stage-two trigger sources.
// registers: control, command, status, both ranks and the slot read port.
// assumes an apb master on pclk; channel pins are asynchronous.
// assumes one transfer at a time; a slot read in wait mode may stall
// for as long as no stage-one trigger arrives, so the master needs its
// own limit on how long it waits.
`timescale 1ns/1ps
`default_nettype none

// Function
// - two policies, every-trigger after reset
// - policy applies to all sixteen channels
// - every-trigger: each stage-one overwrites rank one
// - every-trigger: stage-two moves latest sample
// - first-after-transfer: only first stage-one accepted
// - first-after-transfer: earliest sample is transferred
// - reset acts as stage-two without stage-one
// - immediate and wait read modes, immediate default
// - immediate read returns rank two at once
// - read sample waits for external stage-two
// - wait mode stalls until new data
// - wait mode returns the rank-two sample
// - each wait read consumes one stage-one when stage two is read-driven
// - immediate read may refresh rank one only
// - channel zero is least significant bit
// - stage-two copies whole rank one
// - read-driven both: stage-one, stage-two, then read
module tric_capture
  import tric_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRIC_CHANNELS-1:0] input_channel_group,
  input wire logic stage_one_edge_input,
  input wire logic stage_two_edge_input
);

  // ==========================================================================
  // slot read sequencer states and block state
  typedef enum logic [1:0] {tric_idle, tric_wait, tric_s2, tric_done} tric_rd_t;

  // configuration as written by software
  tric_cfg_t cfg;
  logic [TRIC_CHANNELS-1:0] ch_a;
  logic [TRIC_CHANNELS-1:0] ch_b;
  logic [TRIC_CHANNELS-1:0] ch_c;
  logic [TRIC_CHANNELS-1:0] ch_live;
  // the two capture ranks
  logic [TRIC_CHANNELS-1:0] rank_one;
  logic [TRIC_CHANNELS-1:0] rank_two;
  // policy and wait-mode flags
  logic armed;
  logic new_data;
  tric_rd_t rd_state;
  logic ext1_pulse;
  logic ext2_pulse;
  logic setup;
  logic rd_read;
  logic rd_start;
  logic s1_pulse;
  logic s2_pulse;
  logic s1_accept;
  logic [TRIC_CHANNELS-1:0] s2_source;

  // ==========================================================================
  // input synchronisers
  // ext1 feeds stage one, ext2 stage two; both pins idle high
  tric_edge_sync u_ext1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(stage_one_edge_input),
    .fall_pulse(ext1_pulse)
  );

  tric_edge_sync u_ext2 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(stage_two_edge_input),
    .fall_pulse(ext2_pulse)
  );

  // channel states use three flops; a change counts once b and c agree.
  // the held live level ignores a channel that is still settling, so a
  // capture never takes a half-resolved bit
  genvar gi;
  generate
    for (gi = 0; gi < TRIC_CHANNELS; gi++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_a[gi] <= 1'b0;
          ch_b[gi] <= 1'b0;
          ch_c[gi] <= 1'b0;
          ch_live[gi] <= 1'b0;
        end else begin
          ch_a[gi] <= input_channel_group[gi];
          ch_b[gi] <= ch_a[gi];
          ch_c[gi] <= ch_b[gi];
          if (ch_b[gi] == ch_c[gi]) begin
            ch_live[gi] <= ch_c[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // apb decode; every effect is taken at the setup edge only, so the
  // access cycles that follow can never fire a trigger twice
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_stat;
  logic hit_rank1;
  logic hit_rank2;
  logic hit_read;
  logic hit_none;
  always_comb begin
    hit_ctrl = 1'b0;
    hit_cmd = 1'b0;
    hit_stat = 1'b0;
    hit_rank1 = 1'b0;
    hit_rank2 = 1'b0;
    hit_read = 1'b0;
    hit_none = 1'b0;
    case (paddr)
      TRIC_CTRL_OFF: hit_ctrl = 1'b1;
      TRIC_CMD_OFF: hit_cmd = 1'b1;
      TRIC_STAT_OFF: hit_stat = 1'b1;
      TRIC_RANK1_OFF: hit_rank1 = 1'b1;
      TRIC_RANK2_OFF: hit_rank2 = 1'b1;
      TRIC_READ_OFF: hit_read = 1'b1;
      default: hit_none = 1'b1;
    endcase
  end

  assign setup = psel & ~penable;
  assign rd_read = setup & ~pwrite & hit_read;
  assign rd_start = rd_read & (rd_state == tric_idle);

  // software stage triggers from the command register
  logic sw_s1;
  logic sw_s2;
  assign sw_s1 = setup & pwrite & hit_cmd & pwdata[TRIC_CMD_S1_BIT];
  assign sw_s2 = setup & pwrite & hit_cmd & pwdata[TRIC_CMD_S2_BIT];

  // ==========================================================================
  // trigger sources
  always_comb begin
    s1_pulse = 1'b0;
    case (cfg.stage_one_source_select)
      TRIC_SRC_EXT: s1_pulse = ext1_pulse;
      TRIC_SRC_READ: s1_pulse = rd_start;
      TRIC_SRC_SW: s1_pulse = sw_s1;
      default: s1_pulse = 1'b0;
    endcase
  end

  // read-driven stage two fires one cycle after the read's stage one in immediate mode, two cycles after in wait mode,
  // so the copy always sees the sample that the same read took
  always_comb begin
    s2_pulse = 1'b0;
    case (cfg.stage_two_source_select)
      TRIC_SRC_EXT: s2_pulse = ext2_pulse;
      TRIC_SRC_READ: s2_pulse = (rd_state == tric_s2);
      TRIC_SRC_SW: s2_pulse = sw_s2;
      default: s2_pulse = 1'b0;
    endcase
  end

  // policy gate shared by all channels at once; in first-after mode the
  // gate closes on the first stage one and reopens on the next stage two
  logic policy_open;
  assign policy_open = (cfg.capture_policy_select == tric_every_trigger) | armed;
  assign s1_accept = s1_pulse & policy_open;

  // ==========================================================================
  // configuration register; a write lands at its setup edge and the
  // reserved bits are dropped, so they always read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= TRIC_CFG_RST;
    end else if (setup & pwrite & (paddr == TRIC_CTRL_OFF)) begin
      cfg.capture_policy_select <= tric_policy_t'(pwdata[TRIC_CTRL_POLICY_BIT]);
      cfg.read_wait_select <= tric_rmode_t'(pwdata[TRIC_CTRL_WAIT_BIT]);
      cfg.stage_one_source_select <= pwdata[TRIC_CTRL_S1SRC_LSB +: 2];
      cfg.stage_two_source_select <= pwdata[TRIC_CTRL_S2SRC_LSB +: 2];
    end
  end

  // ==========================================================================
  // rank one: sampled from live inputs on an accepted stage-one trigger;
  // a rejected trigger leaves the register exactly as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rank_one <= '0;
    end else if (s1_accept) begin
      rank_one <= ch_live;
    end
  end

  // rank two: whole-register copy on stage two; a same-cycle stage one
  // is forwarded so a read-driven sample is never one trigger stale
  assign s2_source = s1_accept ? ch_live : rank_one;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rank_two <= '0;
    end else if (s2_pulse) begin
      rank_two <= s2_source;
    end
  end

  // arm flag: reset behaves as an internal stage two with no stage one;
  // when stage one and stage two meet in one cycle, stage two wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b1;
    end else if (s2_pulse) begin
      armed <= 1'b1;
    end else if (s1_pulse) begin
      armed <= 1'b0;
    end
  end

  // new data: valid stage one since the last stage two; set beats clear
  // so a capture landing with the transfer is kept for the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_data <= 1'b0;
    end else if (s1_accept) begin
      new_data <= 1'b1;
    end else if (s2_pulse) begin
      new_data <= 1'b0;
    end
  end

  // ==========================================================================
  // slot read sequencer
  // idle -> wait -> s2 -> done in wait mode, else idle -> (s2) -> done; the start edge is the setup edge, and a
  // read-driven stage one fires at that same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state <= tric_idle;
    end else begin
      case (rd_state)
        tric_idle: begin
          if (rd_start) begin
            if (cfg.read_wait_select == tric_new_data_wait_mode) begin
              rd_state <= tric_wait;
            end else if (cfg.stage_two_source_select == TRIC_SRC_READ) begin
              rd_state <= tric_s2;
            end else begin
              rd_state <= tric_done;
            end
          end
        end
        tric_wait: begin
          // read-driven stage one set new_data in the start cycle
          if (new_data | s1_accept) begin
            rd_state <= tric_s2;
          end
        end
        // stage two copies rank one in this state when read-driven
        tric_s2: rd_state <= tric_done;
        // the answer is loaded here and stands for one cycle
        tric_done: rd_state <= tric_idle;
        default: rd_state <= tric_idle;
      endcase
    end
  end

  // ==========================================================================
  // read words; fields sit at the package positions, reserved bits read zero
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] read_word;
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[TRIC_CTRL_POLICY_BIT] = cfg.capture_policy_select;
    ctrl_word[TRIC_CTRL_WAIT_BIT] = cfg.read_wait_select;
    ctrl_word[TRIC_CTRL_S1SRC_LSB +: 2] = cfg.stage_one_source_select;
    ctrl_word[TRIC_CTRL_S2SRC_LSB +: 2] = cfg.stage_two_source_select;
  end

  // status: bit 0 new data, bit 1 armed, bit 2 slot read in progress
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[0] = new_data;
    stat_word[1] = armed;
    stat_word[2] = (rd_state != tric_idle);
  end

  // the slot port is not in this mux: its word comes from the sequencer
  always_comb begin
    read_word = 32'h00000000;
    if (hit_ctrl) begin
      read_word = ctrl_word;
    end else if (hit_stat) begin
      read_word = stat_word;
    end else if (hit_rank1) begin
      read_word = {16'h0000, rank_one};
    end else if (hit_rank2) begin
      read_word = {16'h0000, rank_two};
    end
  end

  // ==========================================================================
  // apb answer: read port answers from the sequencer, others next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (pready) begin
        prdata <= '0;
      end else if (rd_state == tric_done) begin
        pready <= 1'b1;
        prdata <= {16'h0000, rank_two};
      end else if (setup & ~rd_read) begin
        // every other word answers one cycle after its setup edge; writes
        // return zero data, and only offsets outside the map raise an error
        pready <= 1'b1;
        pslverr <= hit_none;
        if (!pwrite) begin
          prdata <= read_word;
        end
      end
    end
  end

endmodule : tric_capture
`default_nettype wire

// file: sim/tric_capture_chk.sv
// tric_capture_chk: apb-side timing and data checks for tric_capture.
// assumes it is bound to tric_capture and sees only its apb ports.
`timescale 1ns/1ps
`default_nettype none
module tric_capture_chk
  import tric_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] cfg;
  wire logic setup = psel && !penable;
  wire logic rd_slot = setup && !pwrite && paddr == TRIC_READ_OFF;
  wire logic imm = !cfg[TRIC_CTRL_WAIT_BIT];
  wire logic s2_read = cfg[9:8] == TRIC_SRC_READ;
  // shadow of the control register, so slot timing can be judged per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 10'h220;
    end else if (setup && pwrite && paddr == TRIC_CTRL_OFF) begin
      cfg <= pwdata[9:0];
    end
  end
  // ==========================================================================
  // properties
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  sequence s_two_wait;
    !pready [*2] ##1 pready;
  endsequence
  property p_reg_ans;
    setup && paddr != TRIC_READ_OFF |=> pready;
  endproperty
  a_reg_ans: assert property (p_reg_ans) else $error("register answer late");
  property p_err;
    setup && paddr > TRIC_READ_OFF && paddr[1:0] == 2'h0 |=> pready && pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_imm_ext;
    rd_slot && imm && !s2_read |=> s_one_wait;
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("immediate read timing");
  property p_imm_int;
    rd_slot && imm && s2_read |=> s_two_wait;
  endproperty
  a_imm_int: assert property (p_imm_int) else $error("read-driven sequence timing");
  property p_wait;
    rd_slot && !imm |=> !pready;
  endproperty
  a_wait: assert property (p_wait) else $error("wait read answered at once");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_quiet;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside answer");
  property p_upper;
    pready && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_ctrl_back;
    setup && !pwrite && paddr == TRIC_CTRL_OFF |=> prdata[9:0] == (cfg & 10'h333);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
endmodule : tric_capture_chk
`default_nettype wire

// file: sim/tric_field_model.sv
// tric_field_model: field side, channel levels and two trigger pins.
// assumes calls start just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module tric_field_model (
  input wire logic pclk,
  output logic [15:0] chans,
  output logic s1_pin,
  output logic s2_pin
);
  // pins idle high; a capture request is a falling edge
  initial begin
    chans = 16'h0;
    s1_pin = 1'b1;
    s2_pin = 1'b1;
  end
  // levels settle long enough to pass the synchroniser before any edge
  task automatic put(input logic [15:0] v);
    chans <= v;
    repeat (8) @(posedge pclk);
  endtask : put
  // low for six cycles so the edge is never lost in the sync flops
  task automatic fall(input logic two, input logic [15:0] v);
    put(v);
    if (two) begin
      s2_pin <= 1'b0;
    end else begin
      s1_pin <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    s1_pin <= 1'b1;
    s2_pin <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : fall
endmodule : tric_field_model
`default_nettype wire

// file: sim/testbench.sv
// testbench: apb master, expectation queue and monitor for tric_capture.
// assumes tric_field_model drives the channels and trigger pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tric_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s1_pin, s2_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] chans, r, a;
  logic [32:0] exp_q[$];
  logic [32:0] ev;
  int mismatches, checks;
  tric_capture tric_capture_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_channel_group(chans),
    .stage_one_edge_input(s1_pin), .stage_two_edge_input(s2_pin));
  tric_field_model tric_field_model_inst (.pclk(pclk), .chans(chans), .s1_pin(s1_pin),
    .s2_pin(s2_pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // one apb transfer; a read notes its expected {pslverr, prdata}
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : xfer
  // monitor: every read answer is matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      ev = exp_q.size() > 0 ? exp_q.pop_front() : {1'b1, 32'hFFFFFFFF};
      check("error flag", {31'h0, pslverr}, {31'h0, ev[32]});
      if (!ev[32]) check("read data", prdata, ev[31:0]);
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    mismatches = 0;
    checks = 0;
    r = 16'h7F8B;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, TRIC_CTRL_OFF, 32'h0, {1'b0, 32'h220});
    xfer(1'b0, TRIC_STAT_OFF, 32'h0, {1'b0, 32'h2});
    xfer(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    xfer(1'b0, TRIC_CMD_OFF, 32'h0, {1'b0, 32'h0});
    r = lfsr(r);
    a = r;
    tric_field_model_inst.put(a);
    xfer(1'b0, TRIC_READ_OFF, 32'h0, {17'h0, a});
    // read samples rank one but rank two waits for the external edge
    xfer(1'b1, TRIC_CTRL_OFF, 32'h120, 33'h0);
    r = lfsr(r);
    tric_field_model_inst.put(r);
    xfer(1'b0, TRIC_READ_OFF, 32'h0, {17'h0, a});
    xfer(1'b0, TRIC_RANK1_OFF, 32'h0, {17'h0, r});
    tric_field_model_inst.fall(1'b1, r);
    xfer(1'b0, TRIC_RANK2_OFF, 32'h0, {17'h0, r});
    // three captures, then software transfer: last wins or first wins
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, TRIC_CTRL_OFF, 32'h310 | p, 33'h0);
      for (int k = 0; k < 3; k++) begin
        r = lfsr(r);
        if (k == 0) a = r;
        tric_field_model_inst.fall(1'b0, r);
      end
      xfer(1'b1, TRIC_CMD_OFF, 32'h2, 33'h0);
      xfer(1'b0, TRIC_RANK2_OFF, 32'h0, {17'h0, p ? a : r});
    end
    // wait mode: each read stalls until its own external capture arrives
    xfer(1'b1, TRIC_CTRL_OFF, 32'h212, 33'h0);
    for (int k = 0; k < 2; k++) begin
      r = lfsr(r);
      fork
        xfer(1'b0, TRIC_READ_OFF, 32'h0, {17'h0, r});
        begin
          repeat (20) @(posedge pclk);
          tric_field_model_inst.fall(1'b0, r);
        end
      join
    end
    xfer(1'b0, TRIC_STAT_OFF, 32'h0, {1'b0, 32'h2});
    // software stage one with stage two held: rank two must not move
    a = r;
    r = lfsr(r);
    tric_field_model_inst.put(r);
    xfer(1'b1, TRIC_CTRL_OFF, 32'h030, 33'h0);
    xfer(1'b1, TRIC_CMD_OFF, 32'h3, 33'h0);
    xfer(1'b0, TRIC_RANK1_OFF, 32'h0, {17'h0, r});
    xfer(1'b0, TRIC_READ_OFF, 32'h0, {17'h0, a});
    report_and_stop();
  end
endmodule : testbench
bind tric_capture tric_capture_chk tric_capture_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
